/* File: rtl/usb_ep_ctrl_pkg.sv */
// Purpose: Shared constants for the USB endpoint control register bank.
// Assumes: Classic Wishbone slave with 32-bit data, one register per word.
// Notes:   All offsets are byte addresses.
package usb_ep_ctrl_pkg;

    localparam logic [7:0] OFS_REQ_FLAGS  = 8'h00;
    localparam logic [7:0] OFS_CLK_CTRL   = 8'h04;
    localparam logic [7:0] OFS_ADDR_WAKE  = 8'h08;
    localparam logic [7:0] OFS_HALT_BITS  = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h14;
    localparam logic [7:0] OFS_CORE_CTRL  = 8'h18;

    localparam int NUM_EP = 4;

    localparam int CLK_SEL_LSB     = 0;
    localparam int CLK_USB_CLOCK_ENABLE_BIT = 3;
    localparam int CLK_SUSP_BIT    = 4;
    localparam int CLK_PLLSRC_BIT  = 5;
    localparam int CLK_XTAL_BIT    = 6;
    localparam int CLK_DPRES_BIT   = 7;

    localparam int CORE_INTEN_BIT  = 0;
    localparam int CORE_STKFULL_BIT = 1;

    localparam logic [7:0] RST_REQ_FLAGS = 8'h00;
    localparam logic [7:0] RST_CLK_CTRL  = 8'h00;
    localparam logic [7:0] RST_ADDR_WAKE = 8'h00;
    localparam logic [7:0] RST_HALT_BITS = 8'h00;
    localparam logic [3:0] RST_IRQ_MASK  = 4'h0;

    localparam logic [2:0] SEL_LAST_EP = 3'h3;

endpackage : usb_ep_ctrl_pkg

/* File: rtl/ep_flag_cell.sv */
// Purpose: One sticky endpoint event flag with software clear.
// Assumes: Set and clear are single-cycle strobes on i_clock.
// Notes:   A set in the same cycle as a clear wins.
`timescale 1ns/1ps
module ep_flag_cell
(
    // Clock and reset
    input  wire logic i_clock,
    input  wire logic i_sys_rst,
    // Control
    input  wire logic i_set,
    input  wire logic i_clr,
    // State
    output logic      o_flag
);

    logic flag_q;
    logic flag_d;

    assign flag_d = i_set | (flag_q & ~i_clr);

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
            flag_q <= 1'b0;
        else
            flag_q <= flag_d;
    end

    assign o_flag = flag_q;

endmodule // ep_flag_cell

/* File: rtl/usb_endpoint_control_regs.sv */
// Purpose: Endpoint control/status register bank for a full-speed USB function.
// Assumes: Classic Wishbone slave, single clock, synchronous active-high reset.
// Notes on behaviour
// - Engine access to endpoint n sets flag n.
// - Flag interrupts only if enabled and stack not full.
// - Flags stay set until software writes zero.
// - Upper four bits of flags, halts read zero.
// - Three-bit select picks endpoint FIFO zero to three.
// - Unimplemented endpoint selection gives no FIFO access.
// - Clock enable bit runs or stops USB clock.
// - Clock source bit picks oscillator or PLL clock.
// - Resistor connect bit drives D+ pull, resets off.
// - Address register resets to zero.
// - Bit zero wakeup enable, bits one-seven address.
// - Bus reset clears all halt bits.
// - Setup token clears endpoint zero halt bit.
// Notes: Event status reads clear; a set in the read cycle survives.
`timescale 1ns/1ps
module usb_endpoint_control_regs
(
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_sys_rst,
    // Wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    // Serial interface engine events
    input  wire logic [3:0]  i_ep_access,
    input  wire logic        i_bus_reset,
    input  wire logic        i_setup_token,
    // Endpoint FIFO request from the core
    input  wire logic        i_fifo_req,
    // Control outputs
    output logic      [3:0]  o_fifo_ep_onehot,
    output logic             o_usb_clock_enable,
    output logic             o_suspend_power_save,
    output logic             o_pll_clock_source_select,
    output logic             o_crystal_freq_select,
    output logic             o_dplus_resistor_connect,
    output logic             o_remote_wakeup_enable,
    output logic      [6:0]  o_device_address_field,
    output logic      [3:0]  o_endpoint_halt_bits,
    // Interrupts
    output logic             o_usb_irq,
    output logic             o_irq
);

    logic [7:0]  clk_ctrl_q;
    logic [7:0]  addr_wake_q;
    logic [3:0]  halt_q;
    logic [3:0]  halt_d;
    logic [3:0]  irq_mask_q;
    logic [3:0]  irq_stat_q;
    logic [3:0]  irq_stat_d;
    logic [1:0]  core_ctrl_q;
    logic [3:0]  fifo_q;
    logic [3:0]  fifo_d;
    logic        usb_irq_q;
    logic        irq_q;
    logic        ack_q;
    logic [31:0] dat_q;
    logic [3:0]  req_flags;

    wire         wb_req     = i_wb_cyc & i_wb_stb & ~ack_q;
    wire         wb_wr      = wb_req & i_wb_we & i_wb_sel[0];
    wire         wb_rd      = wb_req & ~i_wb_we;
    wire         hit_flags  = (i_wb_adr == usb_ep_ctrl_pkg::OFS_REQ_FLAGS);
    wire         hit_clk    = (i_wb_adr == usb_ep_ctrl_pkg::OFS_CLK_CTRL);
    wire         hit_addr   = (i_wb_adr == usb_ep_ctrl_pkg::OFS_ADDR_WAKE);
    wire         hit_halt   = (i_wb_adr == usb_ep_ctrl_pkg::OFS_HALT_BITS);
    wire         hit_stat   = (i_wb_adr == usb_ep_ctrl_pkg::OFS_IRQ_STATUS);
    wire         hit_mask   = (i_wb_adr == usb_ep_ctrl_pkg::OFS_IRQ_MASK);
    wire         hit_core   = (i_wb_adr == usb_ep_ctrl_pkg::OFS_CORE_CTRL);
    wire [7:0]   wr_byte    = i_wb_dat[7:0];
    wire         flag_wr    = wb_wr & hit_flags;
    wire [2:0]   ep_sel     = clk_ctrl_q[usb_ep_ctrl_pkg::CLK_SEL_LSB +: 3];
    wire         sel_valid  = (ep_sel <= usb_ep_ctrl_pkg::SEL_LAST_EP);
    wire         int_enable = core_ctrl_q[usb_ep_ctrl_pkg::CORE_INTEN_BIT];
    wire         stack_full = core_ctrl_q[usb_ep_ctrl_pkg::CORE_STKFULL_BIT];

    // Only written zeros clear a flag; ones leave it alone.
    genvar g;
    generate
        for (g = 0; g < usb_ep_ctrl_pkg::NUM_EP; g++)
        begin : g_flag
            ep_flag_cell u_flag
            (
                .i_clock   (i_clock),
                .i_sys_rst (i_sys_rst),
                .i_set     (i_ep_access[g]),
                .i_clr     (flag_wr & ~wr_byte[g]),
                .o_flag    (req_flags[g])
            );
        end
    endgenerate

    // Halt bits: software writes, bus reset or setup token clear.
    always_comb
    begin
        halt_d = halt_q;
        if (wb_wr && hit_halt)
            halt_d = wr_byte[3:0];
        if (i_setup_token)
            halt_d[0] = 1'b0;
        if (i_bus_reset)
            halt_d = 4'h0;
    end

    // Sticky event status cleared by reading it; new events win.
    assign irq_stat_d = ((wb_rd && hit_stat) ? 4'h0 : irq_stat_q) | i_ep_access;

    // FIFO path is steered only for an endpoint that exists.
    always_comb
    begin
        fifo_d = 4'h0;
        if (i_fifo_req && sel_valid)
            fifo_d[ep_sel[1:0]] = 1'b1;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            clk_ctrl_q  <= usb_ep_ctrl_pkg::RST_CLK_CTRL;
            addr_wake_q <= usb_ep_ctrl_pkg::RST_ADDR_WAKE;
            halt_q      <= usb_ep_ctrl_pkg::RST_HALT_BITS[3:0];
            irq_mask_q  <= usb_ep_ctrl_pkg::RST_IRQ_MASK;
            irq_stat_q  <= 4'h0;
            core_ctrl_q <= 2'h0;
            fifo_q      <= 4'h0;
            usb_irq_q   <= 1'b0;
            irq_q       <= 1'b0;
        end
        else
        begin
            if (wb_wr && hit_clk)
                clk_ctrl_q <= wr_byte;
            if (wb_wr && hit_addr)
                addr_wake_q <= wr_byte;
            if (wb_wr && hit_mask)
                irq_mask_q <= wr_byte[3:0];
            if (wb_wr && hit_core)
                core_ctrl_q <= wr_byte[1:0];
            halt_q     <= halt_d;
            irq_stat_q <= irq_stat_d;
            fifo_q     <= fifo_d;
            usb_irq_q  <= (|req_flags) & int_enable & ~stack_full;
            irq_q      <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Read mux; unused upper bits are zero-extended.
    logic [31:0] rd_mux;

    always_comb
    begin
        rd_mux = 32'h0;
        if (hit_flags)
            rd_mux = {28'h0, req_flags};
        else if (hit_clk)
            rd_mux = {24'h0, clk_ctrl_q};
        else if (hit_addr)
            rd_mux = {24'h0, addr_wake_q};
        else if (hit_halt)
            rd_mux = {28'h0, halt_q};
        else if (hit_stat)
            rd_mux = {28'h0, irq_stat_q};
        else if (hit_mask)
            rd_mux = {28'h0, irq_mask_q};
        else if (hit_core)
            rd_mux = {30'h0, core_ctrl_q};
    end

    // One wait state: ack one cycle after the strobe, then dropped.
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            ack_q <= 1'b0;
            dat_q <= 32'h0;
        end
        else
        begin
            ack_q <= wb_req;
            if (wb_rd)
                dat_q <= rd_mux;
        end
    end

    assign o_wb_ack                  = ack_q;
    assign o_wb_dat                  = dat_q;
    assign o_fifo_ep_onehot          = fifo_q;
    assign o_usb_clock_enable        = clk_ctrl_q[usb_ep_ctrl_pkg::CLK_USB_CLOCK_ENABLE_BIT];
    assign o_suspend_power_save      = clk_ctrl_q[usb_ep_ctrl_pkg::CLK_SUSP_BIT];
    assign o_pll_clock_source_select = clk_ctrl_q[usb_ep_ctrl_pkg::CLK_PLLSRC_BIT];
    assign o_crystal_freq_select     = clk_ctrl_q[usb_ep_ctrl_pkg::CLK_XTAL_BIT];
    assign o_dplus_resistor_connect  = clk_ctrl_q[usb_ep_ctrl_pkg::CLK_DPRES_BIT];
    assign o_remote_wakeup_enable    = addr_wake_q[0];
    assign o_device_address_field    = addr_wake_q[7:1];
    assign o_endpoint_halt_bits      = halt_q;
    assign o_usb_irq                 = usb_irq_q;
    assign o_irq                     = irq_q;

    chk_flag_set_hold: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        i_ep_access[0] |=> req_flags[0])
        else $error("Endpoint zero flag not set after access.");

    chk_flag_sticky: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (req_flags[1] && !flag_wr) |=> req_flags[1])
        else $error("Endpoint one flag dropped without a write.");

    chk_set_beats_clr: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (flag_wr && !wr_byte[2] && i_ep_access[2]) |=> req_flags[2])
        else $error("Simultaneous set lost to clear.");

    chk_irq_gate: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        $rose(o_usb_irq) |-> $past(int_enable) && !$past(stack_full))
        else $error("USB interrupt raised while gated.");

    chk_halt_bus_rst: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        i_bus_reset |=> (o_endpoint_halt_bits == 4'h0))
        else $error("Halt bits not cleared by bus reset.");

    chk_halt_setup: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        i_setup_token |=> !o_endpoint_halt_bits[0])
        else $error("Endpoint zero halt not cleared by setup token.");

    chk_fifo_sel_bad: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        !sel_valid |=> (o_fifo_ep_onehot == 4'h0))
        else $error("FIFO steered for absent endpoint.");

    chk_upper_zero: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (o_wb_ack && $past(hit_flags || hit_halt)) |-> (o_wb_dat[31:4] == 28'h0))
        else $error("Unused flag or halt bits read non-zero.");

    // The checks below, chk_fifo_onehot aside, watch the outputs one cycle after the cause.
    // Every output is registered, so each check but chk_fifo_onehot looks one edge later.
    // Reset checks run without the disable so that they see the release.
    // Register writes are judged against the byte that was taken.

    // An endpoint one access must raise its own flag.
    chk_flag_one_set: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        i_ep_access[1] |=> req_flags[1])
        else $error("Endpoint one flag not set after access.");

    // Endpoint two flag follows its access line.
    chk_flag_two_set: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        i_ep_access[2] |=> req_flags[2])
        else $error("Endpoint two flag not set after access.");

    // Endpoint three flag follows its access line.
    chk_flag_three_set: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        i_ep_access[3] |=> req_flags[3])
        else $error("Endpoint three flag not set after access.");

    // A written zero with no new access must clear the flag.
    chk_flag_zero_clr: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (flag_wr && !wr_byte[0] && !i_ep_access[0]) |=> !req_flags[0])
        else $error("Endpoint zero flag not cleared by write.");

    // The same holds for the highest endpoint.
    chk_flag_three_clr: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (flag_wr && !wr_byte[3] && !i_ep_access[3]) |=> !req_flags[3])
        else $error("Endpoint three flag not cleared by write.");

    // A pending flag with the gate open must interrupt.
    chk_irq_follow: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        ((|req_flags) && int_enable && !stack_full) |=> o_usb_irq)
        else $error("USB interrupt missing with gate open.");

    // A full stack holds the interrupt back.
    chk_irq_stack: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        stack_full |=> !o_usb_irq)
        else $error("USB interrupt raised with stack full.");

    // A disabled interrupt stays quiet.
    chk_irq_disabled: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        !int_enable |=> !o_usb_irq)
        else $error("USB interrupt raised while disabled.");

    // A valid selection steers exactly the named endpoint.
    chk_fifo_sel_good: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (i_fifo_req && sel_valid) |=> (o_fifo_ep_onehot == (4'h1 << $past(ep_sel[1:0]))))
        else $error("FIFO steered to the wrong endpoint.");

    // Never more than one FIFO at a time.
    chk_fifo_onehot: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        $onehot0(o_fifo_ep_onehot))
        else $error("More than one FIFO selected.");

    // The clock enable output takes the written bit.
    chk_clock_enable: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (wb_wr && hit_clk) |=>
        (o_usb_clock_enable == $past(wr_byte[usb_ep_ctrl_pkg::CLK_USB_CLOCK_ENABLE_BIT])))
        else $error("USB clock enable does not follow write.");

    // The clock source output takes the written bit.
    chk_pll_source: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (wb_wr && hit_clk) |=>
        (o_pll_clock_source_select == $past(wr_byte[usb_ep_ctrl_pkg::CLK_PLLSRC_BIT])))
        else $error("Clock source does not follow write.");

    // The resistor connect output takes the written bit.
    chk_dplus_write: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (wb_wr && hit_clk) |=>
        (o_dplus_resistor_connect == $past(wr_byte[usb_ep_ctrl_pkg::CLK_DPRES_BIT])))
        else $error("Resistor connect does not follow write.");

    // The resistor is disconnected right after reset.
    chk_dplus_reset: assert property (@(posedge i_clock)
        $past(i_sys_rst) |-> !o_dplus_resistor_connect)
        else $error("Resistor connected after reset.");

    // Address and wakeup enable are clear right after reset.
    chk_addr_reset: assert property (@(posedge i_clock)
        $past(i_sys_rst) |-> (o_device_address_field == 7'h00 && !o_remote_wakeup_enable))
        else $error("Address register not zero after reset.");

    // The address field takes the upper seven written bits.
    chk_addr_field: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (wb_wr && hit_addr) |=> (o_device_address_field == $past(wr_byte[7:1])))
        else $error("Device address does not follow write.");

    // The wakeup enable takes written bit zero.
    chk_wakeup_bit: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (wb_wr && hit_addr) |=> (o_remote_wakeup_enable == $past(wr_byte[0])))
        else $error("Wakeup enable does not follow write.");

    // A halt write with no clearing event lands unchanged.
    chk_halt_write: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (wb_wr && hit_halt && !i_bus_reset && !i_setup_token) |=>
        (o_endpoint_halt_bits == $past(wr_byte[3:0])))
        else $error("Halt bits do not follow write.");

endmodule // usb_endpoint_control_regs

/* File: bench/sie_model.sv */
// Purpose: Stand-in for the serial interface engine event lines.
// Assumes: Each event is a one-cycle pulse launched after a rising edge.
// Notes:   Lines rest low between events.
`timescale 1ns/1ps
module sie_model
(
    // Clock
    input  wire logic       i_clock,
    // Events
    output logic      [3:0] o_ep_access,
    output logic            o_bus_reset,
    output logic            o_setup_token
);
    initial
    begin
        o_ep_access   = 4'h0;
        o_bus_reset   = 1'b0;
        o_setup_token = 1'b0;
    end

    // Bits 3:0 are endpoint accesses, bit 4 a bus reset, bit 5 a setup token.
    task automatic pulse(input logic [5:0] ev);
        @(posedge i_clock);
        o_ep_access   <= ev[3:0];
        o_bus_reset   <= ev[4];
        o_setup_token <= ev[5];
        @(posedge i_clock);
        o_ep_access   <= 4'h0;
        o_bus_reset   <= 1'b0;
        o_setup_token <= 1'b0;
        @(posedge i_clock);
    endtask
endmodule // sie_model

/* File: bench/tb_top.sv */
// Purpose: Self-checking bench for the endpoint control register bank.
// Assumes: Registers reached through a classic Wishbone master task.
// Notes:   Software behaviour is played by the tasks below.
`timescale 1ns/1ps
module tb_top;
    logic i_clock = 1'b0, i_sys_rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, fifo_req = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, o_wb_dat, r;
    logic o_wb_ack, o_usb_irq, o_irq, o_wake, bus_rst, setup_tok;
    logic o_cken, o_susp, o_pll, o_xtal, o_dpres;
    logic [3:0] ep_acc, o_onehot, o_halt;
    logic [6:0] o_addr;
    int n_errors = 0, checked = 0;
    always #2.5 i_clock = ~i_clock;
    sie_model sie (.i_clock(i_clock), .o_ep_access(ep_acc), .o_bus_reset(bus_rst),
        .o_setup_token(setup_tok));
    usb_endpoint_control_regs dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF),
        .i_wb_dat(wdat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_ep_access(ep_acc),
        .i_bus_reset(bus_rst), .i_setup_token(setup_tok), .i_fifo_req(fifo_req),
        .o_fifo_ep_onehot(o_onehot), .o_usb_clock_enable(o_cken),
        .o_suspend_power_save(o_susp), .o_pll_clock_source_select(o_pll),
        .o_crystal_freq_select(o_xtal), .o_dplus_resistor_connect(o_dpres),
        .o_remote_wakeup_enable(o_wake), .o_device_address_field(o_addr),
        .o_endpoint_halt_bits(o_halt), .o_usb_irq(o_usb_irq), .o_irq(o_irq));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clock);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        n = 0;
        do
        begin
            @(posedge i_clock);
            n++;
        end
        while (o_wb_ack !== 1'b1 && n < 20);
        r = o_wb_dat;
        cyc <= 1'b0; stb <= 1'b0;
        chk(n < 20, 1'b1, "no ack");
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(r, exp, "read");
    endtask

    task automatic settle();
        repeat (3) @(posedge i_clock);
    endtask

    task automatic t_reset();
        rd(usb_ep_ctrl_pkg::OFS_REQ_FLAGS, 32'h0);
        rd(usb_ep_ctrl_pkg::OFS_CLK_CTRL, 32'h0);
        rd(usb_ep_ctrl_pkg::OFS_ADDR_WAKE, 32'h0);
        rd(usb_ep_ctrl_pkg::OFS_HALT_BITS, 32'h0);
        rd(8'h1C, 32'h0);
    endtask

    task automatic t_flags();
        wb(1'b1, usb_ep_ctrl_pkg::OFS_IRQ_MASK, 32'hF);
        wb(1'b1, usb_ep_ctrl_pkg::OFS_CORE_CTRL, 32'h1);
        for (int n = 0; n < 4; n++)
        begin
            sie.pulse(6'(1 << n));
            rd(usb_ep_ctrl_pkg::OFS_REQ_FLAGS, 32'((2 << n) - 1));
        end
        settle();
        chk(o_usb_irq, 1'b1, "usb irq on");
        chk(o_irq, 1'b1, "irq on");
        wb(1'b1, usb_ep_ctrl_pkg::OFS_CORE_CTRL, 32'h3);
        settle();
        chk(o_usb_irq, 1'b0, "stack full");
        wb(1'b1, usb_ep_ctrl_pkg::OFS_IRQ_MASK, 32'h0);
        settle();
        chk(o_irq, 1'b0, "masked");
        rd(usb_ep_ctrl_pkg::OFS_IRQ_STATUS, 32'hF);
        rd(usb_ep_ctrl_pkg::OFS_IRQ_STATUS, 32'h0);
        wb(1'b1, usb_ep_ctrl_pkg::OFS_REQ_FLAGS, 32'hFE);
        rd(usb_ep_ctrl_pkg::OFS_REQ_FLAGS, 32'hE);
        wb(1'b1, usb_ep_ctrl_pkg::OFS_REQ_FLAGS, 32'h0);
        rd(usb_ep_ctrl_pkg::OFS_REQ_FLAGS, 32'h0);
    endtask

    // An engine access and a clearing write meet at the same edge.
    task automatic t_race();
        fork
            wb(1'b1, usb_ep_ctrl_pkg::OFS_REQ_FLAGS, 32'h0);
            sie.pulse(6'h4);
        join
        rd(usb_ep_ctrl_pkg::OFS_REQ_FLAGS, 32'h4);
    endtask

    // Patterns keep suspend saving only with the clock off and pick either crystal.
    task automatic t_ctrl();
        logic [7:0] p [2] = '{8'hA8, 8'h50};
        fifo_req <= 1'b1;
        foreach (p[k])
            for (int s = 0; s < 5; s++)
            begin
                wb(1'b1, usb_ep_ctrl_pkg::OFS_CLK_CTRL, 32'(p[k] | 8'(s)));
                settle();
                chk({o_dpres, o_xtal, o_pll, o_susp, o_cken}, p[k][7:3], "ctrl");
                chk(o_onehot, (s < 4) ? 4'(1 << s) : 4'h0, "fifo sel");
            end
        fifo_req <= 1'b0;
    endtask

    task automatic t_addr_halt();
        wb(1'b1, usb_ep_ctrl_pkg::OFS_ADDR_WAKE, 32'hAB);
        settle();
        chk({o_addr, o_wake}, 8'hAB, "addr");
        wb(1'b1, usb_ep_ctrl_pkg::OFS_HALT_BITS, 32'hFF);
        rd(usb_ep_ctrl_pkg::OFS_HALT_BITS, 32'hF);
        sie.pulse(6'h20);
        rd(usb_ep_ctrl_pkg::OFS_HALT_BITS, 32'hE);
        sie.pulse(6'h10);
        chk(o_halt, 4'h0, "bus reset");
    endtask

    task automatic summarize();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        #20000;
        n_errors++;
        summarize();
    end

    initial
    begin
        repeat (6) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        t_reset();
        t_flags();
        t_race();
        t_ctrl();
        t_addr_halt();
        summarize();
    end
endmodule // tb_top
